// ---- shared/flash_prot_pkg.sv ----
// constants and types for the flash block erase and protection logic
// assumes a 32-bit word wide array addressed by word index
package flash_prot_pkg;
   localparam int unsigned FLASH_BYTES   = 131072;
   localparam int unsigned WORD_BYTES    = 4;
   localparam int unsigned WORDS         = FLASH_BYTES / WORD_BYTES;
   localparam int unsigned ADDR_W        = 15;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned BLOCK_BYTES   = 1024;
   localparam int unsigned BLOCK_WORDS   = BLOCK_BYTES / WORD_BYTES;
   localparam int unsigned BLOCK_SHIFT   = 8;
   localparam int unsigned BLOCKS        = WORDS / BLOCK_WORDS;
   localparam int unsigned BLOCK_W       = ADDR_W - BLOCK_SHIFT;
   localparam int unsigned REGION_BYTES  = 2048;
   localparam int unsigned REGION_SHIFT  = 9;
   localparam int unsigned REGIONS       = FLASH_BYTES / REGION_BYTES;
   localparam int unsigned REGION_W      = ADDR_W - REGION_SHIFT;
   localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
   localparam logic [DATA_W-1:0] RDATA_RST   = 32'h00000000;
   localparam logic [BLOCK_SHIFT-1:0] LAST_OFS = 8'hFF;
   // read requester codes
   localparam logic [1:0] SRC_FETCH = 2'h0;
   localparam logic [1:0] SRC_DATA  = 2'h1;
   localparam logic [1:0] SRC_DEBUG = 2'h2;
   typedef enum logic {ST_IDLE, ST_ERASE} erase_state_t;
endpackage : flash_prot_pkg

// ---- hdl/flash_block_erase_protect.sv ----
// access, erase and protection logic for a 128 KB on-chip flash array
// assumes protection masks are held stable by system control outside
// Behaviour
// [R1] 128 KB array, 1 KB blocks erased alone
// [R2] erase sets every bit of block to one
// [R3] protection per 2 KB pair of blocks
// [R4] region is read-only or execute-only
// [R5] read-only region refuses program and erase
// [R6] execute-only region refuses program and erase
// [R7] execute-only region serves instruction fetches only
// [R8] permitted read answers in one cycle
// [R9] refusal keeps array, sets sticky clearable flag
// [R10] unprotected region allows all access
`timescale 1ns/10ps
`default_nettype none
module flash_block_erase_protect
   import flash_prot_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic [REGIONS-1:0]  ro_mask_i,
   input  wire logic [REGIONS-1:0]  xo_mask_i,
   input  wire logic                rd_req_i,
   input  wire logic [1:0]          rd_src_i,
   input  wire logic [ADDR_W-1:0]   rd_addr_i,
   output logic                     rd_valid_o,
   output logic                     rd_denied_o,
   output logic [DATA_W-1:0]        rd_data_o,
   input  wire logic                prog_req_i,
   input  wire logic [ADDR_W-1:0]   prog_addr_i,
   input  wire logic [DATA_W-1:0]   prog_data_i,
   output logic                     prog_done_o,
   input  wire logic                erase_req_i,
   input  wire logic [BLOCK_W-1:0]  erase_blk_i,
   output logic                     erase_busy_o,
   output logic                     erase_done_o,
   output logic                     cmd_busy_rej_o,
   input  wire logic                viol_clr_i,
   output logic                     viol_o
);

   // one word per entry; contents are not reset, as real flash keeps them
   logic [DATA_W-1:0] mem [0:WORDS-1]; // [R1]

   erase_state_t            state;
   erase_state_t            next_state;
   logic [BLOCK_W-1:0]      ers_blk;
   logic [BLOCK_W-1:0]      next_ers_blk;
   logic [BLOCK_SHIFT-1:0]  ers_ofs;
   logic [BLOCK_SHIFT-1:0]  next_ers_ofs;

   logic                    next_rd_valid;
   logic                    next_rd_denied;
   logic [DATA_W-1:0]       next_rd_data;
   logic                    next_prog_done;
   logic                    next_erase_busy;
   logic                    next_erase_done;
   logic                    next_cmd_busy_rej;
   logic                    next_viol;

   logic                    mem_we;
   logic [ADDR_W-1:0]       mem_waddr;
   logic [DATA_W-1:0]       mem_wdata;

   logic [REGION_W-1:0]     rd_region;
   logic [REGION_W-1:0]     pg_region;
   logic [REGION_W-1:0]     er_region;
   logic                    rd_xo;
   logic                    pg_locked;
   logic                    er_locked;
   logic                    rd_refuse;
   logic                    pg_refuse;
   logic                    er_refuse;

   // protection lookup: one setting per pair of blocks
   // the region index is simply the address bits above one 2 KB pair
   always_comb begin
      rd_region = rd_addr_i[ADDR_W-1:REGION_SHIFT]; // [R3]
      pg_region = prog_addr_i[ADDR_W-1:REGION_SHIFT]; // [R3]
      er_region = erase_blk_i[BLOCK_W-1:1]; // [R3]
      // both settings at once behaves as execute-only, the stricter one
      rd_xo     = xo_mask_i[rd_region]; // [R4]
      pg_locked = ro_mask_i[pg_region] | xo_mask_i[pg_region]; // [R5] [R6]
      er_locked = ro_mask_i[er_region] | xo_mask_i[er_region]; // [R5] [R6]
      rd_refuse = rd_req_i & rd_xo & (rd_src_i != SRC_FETCH); // [R7]
      pg_refuse = prog_req_i & pg_locked; // [R5] [R6]
      er_refuse = erase_req_i & er_locked; // [R5] [R6]
   end

   // read path: answer registered the cycle after the request
   // limitation: a word written in the same cycle reads back its old value
   always_comb begin
      next_rd_valid  = rd_req_i & ~rd_refuse; // [R8] [R10]
      next_rd_denied = rd_refuse; // [R7]
      next_rd_data   = rd_data_o;
      if (rd_req_i && !rd_refuse) begin
         next_rd_data = mem[rd_addr_i]; // [R8]
      end else if (rd_refuse) begin
         // denied reads return zero so no protected bits leak out
         next_rd_data = RDATA_RST; // [R7]
      end
   end

   // program and erase sequencing
   // trade-off: one word per cycle keeps a single array write port
   always_comb begin
      next_state        = state;
      next_ers_blk      = ers_blk;
      next_ers_ofs      = ers_ofs;
      next_prog_done    = 1'b0;
      next_erase_done   = 1'b0;
      next_cmd_busy_rej = 1'b0;
      mem_we            = 1'b0;
      mem_waddr         = prog_addr_i;
      mem_wdata         = prog_data_i;
      case (state)
         ST_IDLE: begin
            if (erase_req_i) begin
               // erase wins over a program in the same cycle
               // the losing program is reported on cmd_busy_rej_o
               if (!er_refuse) begin
                  next_state   = ST_ERASE; // [R1] [R10]
                  next_ers_blk = erase_blk_i;
                  next_ers_ofs = '0;
               end
               if (prog_req_i) begin
                  next_cmd_busy_rej = 1'b1;
               end
            end else if (prog_req_i && !pg_refuse) begin
               // programming only clears bits, as flash cells allow
               mem_we         = 1'b1; // [R10]
               mem_wdata      = mem[prog_addr_i] & prog_data_i;
               next_prog_done = 1'b1;
            end
         end
         ST_ERASE: begin
            // one word per cycle; only this block's words are touched
            // reads keep running while an erase walks the block
            mem_we    = 1'b1; // [R1]
            mem_waddr = {ers_blk, ers_ofs};
            mem_wdata = ERASED_WORD; // [R2]
            next_ers_ofs = ers_ofs + 1'b1;
            if (ers_ofs == LAST_OFS) begin
               next_state      = ST_IDLE;
               next_erase_done = 1'b1; // [R2]
            end
            if (prog_req_i || erase_req_i) begin
               next_cmd_busy_rej = 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_erase_busy = (next_state == ST_ERASE);
   end

   // sticky violation flag; a new refusal beats a clear in the same cycle
   // busy rejections are not protection faults, so they leave the flag alone
   always_comb begin
      next_viol = viol_o;
      if (viol_clr_i) begin
         next_viol = 1'b0; // [R9]
      end
      if (rd_refuse || (state == ST_IDLE && (er_refuse || (pg_refuse && !erase_req_i)))) begin
         next_viol = 1'b1; // [R9]
      end
   end

   // array write port; refused requests never raise mem_we
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata; // [R9]
      end
   end

   // read answer registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_valid_o  <= 1'b0;
         rd_denied_o <= 1'b0;
         rd_data_o   <= RDATA_RST;
      end else begin
         rd_valid_o  <= next_rd_valid;
         rd_denied_o <= next_rd_denied;
         rd_data_o   <= next_rd_data;
      end
   end

   // program and erase registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state          <= ST_IDLE;
         ers_blk        <= '0;
         ers_ofs        <= '0;
         prog_done_o    <= 1'b0;
         erase_busy_o   <= 1'b0;
         erase_done_o   <= 1'b0;
         cmd_busy_rej_o <= 1'b0;
      end else begin
         state          <= next_state;
         ers_blk        <= next_ers_blk;
         ers_ofs        <= next_ers_ofs;
         prog_done_o    <= next_prog_done;
         erase_busy_o   <= next_erase_busy;
         erase_done_o   <= next_erase_done;
         cmd_busy_rej_o <= next_cmd_busy_rej;
      end
   end

   // sticky flag register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         viol_o <= 1'b0;
      end else begin
         viol_o <= next_viol;
      end
   end

endmodule // flash_block_erase_protect
`default_nettype wire

// ---- testbench/flash_requester.sv ----
// model of the fetch, data and debug requesters on the read port
// assumes the bench asks for one read at a time through go_i
`timescale 1ns/10ps
`default_nettype none
module flash_requester
   import flash_prot_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              go_i,
   input  wire logic [1:0]        src_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   output logic                   rd_req_o,
   output logic [1:0]             rd_src_o,
   output logic [ADDR_W-1:0]      rd_addr_o
);
   initial begin
      rd_req_o = 1'h0;
      rd_src_o = 2'h0;
      rd_addr_o = '0;
   end
   // idle lines toggle so a design that ignores rd_req_o reads garbage
   always @(posedge sys_clk_i) begin
      rd_req_o <= go_i;
      rd_src_o <= go_i ? src_i : ~rd_src_o;
      rd_addr_o <= go_i ? addr_i : ~rd_addr_o;
   end
endmodule // flash_requester
`default_nettype wire

// ---- testbench/flash_prot_checker.sv ----
// assertions on the flash access and protection ports
// assumes it is bound onto the flash block top
`timescale 1ns/10ps
`default_nettype none
module flash_prot_checker
   import flash_prot_pkg::*;
(
   input wire logic sys_clk_i, rst_n_i, rd_req_i, prog_req_i, erase_req_i, viol_clr_i,
   input wire logic [REGIONS-1:0] ro_mask_i, xo_mask_i,
   input wire logic [1:0] rd_src_i,
   input wire logic [ADDR_W-1:0] rd_addr_i, prog_addr_i,
   input wire logic [BLOCK_W-1:0] erase_blk_i,
   input wire logic rd_valid_o, rd_denied_o, prog_done_o, erase_busy_o, erase_done_o, viol_o,
   input wire logic [DATA_W-1:0] rd_data_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic rx = xo_mask_i[rd_addr_i[14:9]];
   wire logic pp = ro_mask_i[prog_addr_i[14:9]] | xo_mask_i[prog_addr_i[14:9]];
   wire logic ep = ro_mask_i[erase_blk_i[6:1]] | xo_mask_i[erase_blk_i[6:1]];
   sequence erase_run; erase_busy_o [*8]; endsequence
   sequence erase_end; ##256 erase_done_o && !erase_busy_o; endsequence
   read_answer_a: assert property (rd_req_i && !(rx && rd_src_i != SRC_FETCH) |=>
      rd_valid_o && !rd_denied_o) else $error("read not answered");
   read_deny_a: assert property (rd_req_i && rx && rd_src_i != SRC_FETCH |=>
      rd_denied_o && !rd_valid_o && rd_data_o == '0 && viol_o) else $error("read not denied");
   prog_block_a: assert property (prog_req_i && pp && !erase_busy_o && !erase_req_i |=>
      !prog_done_o && viol_o) else $error("protected program done");
   prog_open_a: assert property (prog_req_i && !pp && !erase_busy_o && !erase_req_i
      |=> prog_done_o) else $error("program not done");
   erase_block_a: assert property (erase_req_i && !erase_busy_o && ep |=>
      !erase_busy_o && viol_o) else $error("protected erase started");
   erase_start_a: assert property (erase_req_i && !erase_busy_o && !ep |=> erase_run)
      else $error("erase not running");
   erase_time_a: assert property ($rose(erase_busy_o) |-> erase_end)
      else $error("erase length wrong");
   viol_keep_a: assert property (viol_o && !viol_clr_i |=> viol_o)
      else $error("flag lost");
   viol_clear_a: assert property (viol_clr_i && !rd_req_i && !prog_req_i && !erase_req_i
      |=> !viol_o) else $error("flag not cleared");
endmodule // flash_prot_checker
bind flash_block_erase_protect flash_prot_checker flash_prot_checker_inst (.sys_clk_i,
   .rst_n_i, .rd_req_i, .prog_req_i, .erase_req_i, .viol_clr_i, .ro_mask_i, .xo_mask_i,
   .rd_src_i, .rd_addr_i, .prog_addr_i, .erase_blk_i, .rd_valid_o, .rd_denied_o,
   .prog_done_o, .erase_busy_o, .erase_done_o, .viol_o, .rd_data_o);
`default_nettype wire

// ---- testbench/flash_block_erase_protect_test.sv ----
// self-checking bench for the flash erase and protection block
// assumes the requester model drives the read port
`timescale 1ns/10ps
`default_nettype none
module flash_block_erase_protect_test
   import flash_prot_pkg::*;
;
   logic sys_clk_i, rst_n_i, go, rd_req_i, prog_req_i, erase_req_i, viol_clr_i, viol_o;
   logic rd_valid_o, rd_denied_o, prog_done_o, erase_busy_o, erase_done_o, cmd_busy_rej_o;
   logic [REGIONS-1:0] ro_mask_i, xo_mask_i;
   logic [1:0] src, rd_src_i;
   logic [ADDR_W-1:0] addr, rd_addr_i, prog_addr_i;
   logic [DATA_W-1:0] rd_data_o, prog_data_i;
   logic [BLOCK_W-1:0] erase_blk_i;
   int fail_count = 0;
   int checks = 0;
   flash_requester flash_requester_inst (.sys_clk_i, .go_i(go), .src_i(src), .addr_i(addr),
      .rd_req_o(rd_req_i), .rd_src_o(rd_src_i), .rd_addr_o(rd_addr_i));
   flash_block_erase_protect flash_block_erase_protect_inst (.sys_clk_i, .rst_n_i, .ro_mask_i,
      .xo_mask_i, .rd_req_i, .rd_src_i, .rd_addr_i, .rd_valid_o, .rd_denied_o, .rd_data_o,
      .prog_req_i, .prog_addr_i, .prog_data_i, .prog_done_o, .erase_req_i, .erase_blk_i,
      .erase_busy_o, .erase_done_o, .cmd_busy_rej_o, .viol_clr_i, .viol_o);
   task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic rd(input logic [1:0] s, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic v);
      @(posedge sys_clk_i) begin go <= 1'h1; src <= s; addr <= a; end
      @(posedge sys_clk_i) go <= 1'h0;
      // the model adds one edge, the design answers one edge later
      @(posedge sys_clk_i);
      #1 chk("rd_valid", rd_valid_o, v);
      chk("rd_denied", rd_denied_o, !v);
      chk("rd_data", rd_data_o, d);
   endtask
   task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic v);
      @(posedge sys_clk_i) begin prog_req_i <= 1'h1; prog_addr_i <= a; prog_data_i <= d; end
      @(posedge sys_clk_i) prog_req_i <= 1'h0;
      #1 chk("prog_done", prog_done_o, v);
      chk("viol", viol_o, !v);
   endtask
   task automatic erase(input logic [BLOCK_W-1:0] b, input logic v);
      int n;
      n = 0;
      @(posedge sys_clk_i) begin erase_req_i <= 1'h1; erase_blk_i <= b; end
      @(posedge sys_clk_i) erase_req_i <= 1'h0;
      #1 chk("erase_busy", erase_busy_o, v);
      while (erase_busy_o === 1'h1 && n < 300) begin
         @(posedge sys_clk_i) #1 n++;
      end
      chk("erase_len", n, v ? 256 : 0);
      chk("erase_done", erase_done_o, v);
      chk("viol", viol_o, !v);
   endtask
   task automatic clear;
      @(posedge sys_clk_i) viol_clr_i <= 1'h1;
      @(posedge sys_clk_i) viol_clr_i <= 1'h0;
      #1 chk("viol_clr", viol_o, 0);
   endtask
   task automatic busy_rej;
      @(posedge sys_clk_i) begin erase_req_i <= 1'h1; erase_blk_i <= 7'h02; end
      @(posedge sys_clk_i) begin
         erase_req_i <= 1'h0;
         prog_req_i <= 1'h1;
         prog_addr_i <= 15'h0300;
         prog_data_i <= 32'h00000000;
      end
      @(posedge sys_clk_i) prog_req_i <= 1'h0;
      #1 chk("cmd_busy_rej", cmd_busy_rej_o, 1);
      chk("prog_done", prog_done_o, 0);
      chk("viol", viol_o, 0);
      while (erase_busy_o === 1'h1) begin
         @(posedge sys_clk_i) #1;
      end
      chk("erase_done", erase_done_o, 1);
   endtask
   initial begin
      sys_clk_i = 1'h0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // far beyond the roughly 800 cycles the sequence needs
   initial begin
      #200000 fail_count++;
      conclude();
   end
   initial begin
      {rst_n_i, go, prog_req_i, erase_req_i, viol_clr_i, src, addr} = '0;
      {ro_mask_i, xo_mask_i, prog_addr_i, prog_data_i, erase_blk_i} = '0;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'h1;
      #1 chk("rst_flags", {rd_valid_o, rd_denied_o, prog_done_o, erase_busy_o, erase_done_o,
         cmd_busy_rej_o, viol_o}, 7'h00);
      chk("rst_data", rd_data_o, 32'h00000000);
      erase(7'h03, 1'h1);
      prog(15'h0300, 32'hA5A5A5A5, 1'h1);
      erase(7'h02, 1'h1);
      rd(SRC_DATA, 15'h0300, 32'hA5A5A5A5, 1'h1);
      rd(SRC_DEBUG, 15'h02FF, 32'hFFFFFFFF, 1'h1);
      rd(2'h3, 15'h0200, 32'hFFFFFFFF, 1'h1);
      busy_rej();
      @(posedge sys_clk_i) ro_mask_i <= 64'h0000000000000002;
      prog(15'h0300, 32'h00000000, 1'h0);
      erase(7'h02, 1'h0);
      rd(SRC_DEBUG, 15'h0300, 32'hA5A5A5A5, 1'h1);
      clear();
      @(posedge sys_clk_i) begin ro_mask_i <= '0; xo_mask_i <= 64'h0000000000000002; end
      rd(SRC_FETCH, 15'h0300, 32'hA5A5A5A5, 1'h1);
      rd(SRC_DATA, 15'h0300, 32'h00000000, 1'h0);
      rd(SRC_DEBUG, 15'h02FF, 32'h00000000, 1'h0);
      prog(15'h0300, 32'h00000000, 1'h0);
      erase(7'h03, 1'h0);
      rd(SRC_FETCH, 15'h0300, 32'hA5A5A5A5, 1'h1);
      conclude();
   end
endmodule // flash_block_erase_protect_test
`default_nettype wire
